/* shared/spi_sel_pkg.sv */
/*
  Package for the serial select and DMA request block: register offsets,
  field positions, reset values, interrupt bits and shared structs.
  Assumes a plain register port with one-cycle read latency.
*/
// Notes on behaviour
// RULE1 - Three-wire slave ignores select input entirely.
// RULE2 - Manual master mode drives selects from control bits.
// RULE3 - Auto mode asserts select during each transfer only.
// RULE4 - Polarity bit sets active level of selects.
// RULE5 - Manual: writing one activates, zero deactivates line.
// RULE6 - Auto: zero bit keeps line always inactive.
// RULE7 - Slave mode uses first select pin as input.
// RULE8 - DMA reset bit resets request logic, self-clears.
// RULE9 - Receive DMA requests while receive buffer holds data.
// RULE10 - Receive DMA enable cleared when transfer completes.
// RULE11 - Transmit DMA requests automatically, cleared when done.
// RULE12 - Time-out interrupt enable gates slave time-out interrupt.
// RULE13 - Transmit request only when transmit buffer has room.
package spi_sel_pkg;
  localparam logic [7:0] ADDR_SELECT     = 8'h08; // Select line control.
  localparam logic [7:0] ADDR_DMA        = 8'h0C; // DMA request control.
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20; // Sticky event status, read only.
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h24; // Interrupt enable.
  localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h28; // Write one to clear.
  localparam logic [7:0] ADDR_LINK_STATE = 8'h2C; // Live pin and request state.

  localparam int SEL_LINES_LSB   = 0;
  localparam int SEL_POLARITY    = 2;
  localparam int SEL_AUTO        = 3;
  localparam int SEL_THREE_WIRE  = 4;
  localparam int SEL_TIMEOUT_IEN = 5;
  localparam int DMA_TX_EN       = 0;
  localparam int DMA_RX_EN       = 1;
  localparam int DMA_RESET       = 2;

  localparam int EV_TIMEOUT = 0; // Slave time-out event.
  localparam int EV_RX_DONE = 1; // Receive DMA finished.
  localparam int EV_TX_DONE = 2; // Transmit DMA finished.
  localparam int EV_SEL_ACT = 3; // Slave select became active.
  localparam int EV_COUNT   = 4;

  localparam logic [5:0]          SELECT_RESET = 6'h00;
  localparam logic [2:0]          DMA_RESET_VAL = 3'h0;
  localparam logic [EV_COUNT-1:0] EV_RESET = 4'h0;
  // Select pin synchroniser starts at the idle level of an active-low pin.
  // This keeps a false select edge from following reset.
  localparam logic [1:0]          SEL_SYNC_RESET = 2'h1;

  // Register port request from the processor side.
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

  // Handshake signals exchanged with the DMA controller.
  typedef struct packed {
    logic rx_done; // Receive block count exhausted.
    logic tx_done; // Transmit block count exhausted.
    logic rx_ack;  // One receive word taken.
    logic tx_ack;  // One transmit word delivered.
  } dma_in_s;
endpackage

/* src/spi_select_and_dma_request.sv */
/*
  Slave select and DMA request control of a serial peripheral controller.
  Assumes the shift engine reports transfer activity and buffer levels on
  the system clock, and that pins from outside arrive asynchronously.
*/
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module spi_select_and_dma_request (
  input  wire logic                 clk_i,          // System clock, 200 MHz.
  input  wire logic                 reset_i,        // Asynchronous, active high.
  input  wire spi_sel_pkg::reg_req_s req_i,         // Register port request.
  output logic [31:0]               rdata_o,        // Read data, one cycle later.
  input  wire logic                 master_mode_i,  // High when the engine is leader.
  input  wire logic                 xfer_busy_i,    // Engine is shifting a word.
  input  wire logic                 timeout_i,      // Slave time-out pulse.
  input  wire logic                 rx_not_empty_i, // Receive buffer holds data.
  input  wire logic                 tx_has_room_i,  // Transmit buffer can take a word.
  input  wire spi_sel_pkg::dma_in_s  dma_i,          // DMA controller handshake.
  input  wire logic                 select0_pin_i,  // First select pin, input side.
  input  wire logic                 serial_clock_pin_i, // Link clock, sampled.
  output logic [1:0]                select_lines_o, // Select pin output levels.
  output logic [1:0]                select_oe_o,    // Select output enables.
  output logic                      slave_selected_o, // Slave is addressed.
  output logic                      link_clk_rise_o,  // Serial clock rising edge pulse.
  output logic                      rx_dma_req_o,   // Receive request to DMA.
  output logic                      tx_dma_req_o,   // Transmit request to DMA.
  output logic                      dma_logic_reset_o, // Pulse resetting DMA logic.
  output logic                      irq_o           // Level interrupt.
);
  import spi_sel_pkg::*;

  logic [5:0]          select_ctl_r;   // Select control register.
  logic [1:0]          dma_en_r;       // Transmit and receive enables.
  logic                dma_rst_r;      // Self-clearing DMA reset pulse.
  logic [EV_COUNT-1:0] ev_status_r;    // Sticky event bits.
  logic [EV_COUNT-1:0] ev_enable_r;    // Event enable bits.
  logic [EV_COUNT-1:0] ev_set;         // Events arriving this cycle.
  logic [1:0]          sel_sync1_r;    // Select pin, first stage.
  logic [1:0]          sel_sync2_r;    // Select pin, second stage.
  logic [1:0]          sclk_sync1_r;   // Serial clock, first stage.
  logic [1:0]          sclk_sync2_r;   // Serial clock, second stage and history.
  logic                sel_active;     // Select input is in its active state.
  logic                sel_active_q_r; // Previous active state, for edge detect.
  logic [1:0]          sel_active_lvl; // Per line activity before polarity.
  logic [1:0]          select_nxt;     // Next select pin levels.

  // Write strobe decode, used by every register process.
  function automatic logic wr_hit(input reg_req_s r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // Select control register; software writes steer the select pins.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      select_ctl_r <= SELECT_RESET;
    end else if (wr_hit(req_i, ADDR_SELECT)) begin
      select_ctl_r <= req_i.wdata[5:0];
    end
  end

  // DMA reset bit is a one-cycle pulse; writing zero leaves it alone. [RULE8]
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dma_rst_r <= 1'b0;
    end else begin
      dma_rst_r <= wr_hit(req_i, ADDR_DMA) && req_i.wdata[DMA_RESET];
    end
  end

  // DMA enables: software sets, completion clears; reset pulse clears both.
  // A completion in the same cycle as a write wins, since the block is done.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dma_en_r <= DMA_RESET_VAL[1:0];
    end else if (dma_rst_r) begin
      dma_en_r <= 2'h0; // [RULE8]
    end else begin
      if (dma_i.rx_done) begin
        dma_en_r[DMA_RX_EN] <= 1'b0; // [RULE10]
      end else if (wr_hit(req_i, ADDR_DMA)) begin
        dma_en_r[DMA_RX_EN] <= req_i.wdata[DMA_RX_EN]; // [RULE9]
      end
      if (dma_i.tx_done) begin
        dma_en_r[DMA_TX_EN] <= 1'b0; // [RULE11]
      end else if (wr_hit(req_i, ADDR_DMA)) begin
        dma_en_r[DMA_TX_EN] <= req_i.wdata[DMA_TX_EN]; // [RULE11]
      end
    end
  end

  // Requests: receive while data waits, transmit while there is room.
  // Held low during the reset pulse so no stale request escapes.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_dma_req_o <= 1'b0;
      tx_dma_req_o <= 1'b0;
    end else begin
      rx_dma_req_o <= dma_en_r[DMA_RX_EN] && rx_not_empty_i && !dma_rst_r
                      && !dma_i.rx_done && !dma_i.rx_ack; // [RULE9]
      tx_dma_req_o <= dma_en_r[DMA_TX_EN] && tx_has_room_i && !dma_rst_r
                      && !dma_i.tx_done && !dma_i.tx_ack; // [RULE11] [RULE13]
    end
  end

  assign dma_logic_reset_o = dma_rst_r;

  // Two-flop synchronisers for the select input and serial clock pins.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sel_sync1_r  <= SEL_SYNC_RESET; // Idle level, so no false edge follows reset.
      sel_sync2_r  <= SEL_SYNC_RESET;
      sclk_sync1_r <= 2'h0;
      sclk_sync2_r <= 2'h0;
    end else begin
      sel_sync1_r  <= {1'b0, select0_pin_i};
      sel_sync2_r  <= sel_sync1_r;
      sclk_sync1_r <= {1'b0, serial_clock_pin_i};
      sclk_sync2_r <= {sclk_sync2_r[0], sclk_sync1_r[0]};
    end
  end

  // Edge found on the synchronised copy only, never on the first stage.
  assign link_clk_rise_o = sclk_sync2_r[0] && !sclk_sync2_r[1];

  // Slave view of select: polarity applied; three-wire forces selected.
  assign sel_active = select_ctl_r[SEL_THREE_WIRE] ? 1'b1 // [RULE1]
                    : (sel_sync2_r[0] == select_ctl_r[SEL_POLARITY]); // [RULE4] [RULE7]

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sel_active_q_r   <= 1'b0;
      slave_selected_o <= 1'b0;
    end else begin
      sel_active_q_r   <= sel_active;
      slave_selected_o <= !master_mode_i && sel_active;
    end
  end

  // Master select levels: manual follows bits, auto gates with busy.
  always_comb begin
    if (select_ctl_r[SEL_AUTO]) begin
      sel_active_lvl = select_ctl_r[1:0] & {2{xfer_busy_i}}; // [RULE3] [RULE6]
    end else begin
      sel_active_lvl = select_ctl_r[1:0]; // [RULE2] [RULE5]
    end
    // Active level is the polarity bit; inactive is its inverse.
    select_nxt = select_ctl_r[SEL_POLARITY] ? sel_active_lvl : ~sel_active_lvl; // [RULE4]
  end

  // Pin outputs registered; in slave mode line 0 is released as input.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      select_lines_o <= 2'h3;
      select_oe_o    <= 2'h0;
    end else begin
      select_lines_o <= select_nxt;
      select_oe_o    <= master_mode_i ? 2'h3 : 2'h2; // [RULE7]
    end
  end

  // Event sources; the time-out is gated by its own enable bit too.
  assign ev_set[EV_TIMEOUT] = timeout_i && !master_mode_i && select_ctl_r[SEL_TIMEOUT_IEN]; // [RULE12]
  assign ev_set[EV_RX_DONE] = dma_i.rx_done && dma_en_r[DMA_RX_EN];
  assign ev_set[EV_TX_DONE] = dma_i.tx_done && dma_en_r[DMA_TX_EN];
  assign ev_set[EV_SEL_ACT] = !master_mode_i && sel_active && !sel_active_q_r;

  // Sticky status: a set in the clear cycle wins over the clear.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ev_status_r <= EV_RESET;
    end else if (wr_hit(req_i, ADDR_IRQ_CLEAR)) begin
      ev_status_r <= (ev_status_r & ~req_i.wdata[EV_COUNT-1:0]) | ev_set;
    end else begin
      ev_status_r <= ev_status_r | ev_set;
    end
  end

  // Interrupt enable register.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ev_enable_r <= EV_RESET;
    end else if (wr_hit(req_i, ADDR_IRQ_ENABLE)) begin
      ev_enable_r <= req_i.wdata[EV_COUNT-1:0];
    end
  end

  // Interrupt is a level while any enabled status bit is set.
  assign irq_o = |(ev_status_r & ev_enable_r); // [RULE12]

  // Read data registered one cycle after the strobe; unmapped reads zero.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 32'h0;
    end else if (req_i.rd) begin
      case (req_i.addr)
        ADDR_SELECT:     rdata_o <= {26'h0, select_ctl_r};
        ADDR_DMA:        rdata_o <= {29'h0, 1'b0, dma_en_r};
        ADDR_IRQ_STATUS: rdata_o <= {28'h0, ev_status_r};
        ADDR_IRQ_ENABLE: rdata_o <= {28'h0, ev_enable_r};
        ADDR_LINK_STATE: rdata_o <= {26'h0, tx_dma_req_o, rx_dma_req_o, slave_selected_o,
                                     sclk_sync2_r[0], select_lines_o};
        default:         rdata_o <= 32'h0;
      endcase
    end else begin
      rdata_o <= 32'h0;
    end
  end
endmodule

/* verification/spi_sel_props.sv */
/* Checker for the select and DMA request block, bound to its top module.
   Assumes req_i shows each register access at the edge that takes it. */
`timescale 1ns/1ps
module spi_sel_props
  import spi_sel_pkg::*;
(
  input wire logic                  clk_i,
  input wire logic                  reset_i,
  input wire spi_sel_pkg::reg_req_s req_i,
  input wire logic                  master_mode_i,
  input wire logic                  xfer_busy_i,
  input wire logic                  timeout_i,
  input wire logic                  rx_not_empty_i,
  input wire logic                  tx_has_room_i,
  input wire spi_sel_pkg::dma_in_s  dma_i,
  input wire logic [1:0]            select_lines_o,
  input wire logic [1:0]            select_oe_o,
  input wire logic                  slave_selected_o,
  input wire logic                  rx_dma_req_o,
  input wire logic                  tx_dma_req_o,
  input wire logic                  dma_logic_reset_o,
  input wire logic                  irq_o
);
  logic [5:0] sel_q; // Select register as last written.
  logic       ien_q; // Time-out interrupt enable as last written.
  // Shadow only what the checks need; the design's copy is not visible.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sel_q <= SELECT_RESET;
      ien_q <= 1'b0;
    end else if (req_i.wr && req_i.addr == ADDR_SELECT) begin
      sel_q <= req_i.wdata[5:0];
    end else if (req_i.wr && req_i.addr == ADDR_IRQ_ENABLE) begin
      ien_q <= req_i.wdata[EV_TIMEOUT];
    end
  end
  // Pin levels a select value and the busy window call for.
  function automatic logic [1:0] want(logic [5:0] q, logic busy);
    logic [1:0] on;
    on = q[SEL_AUTO] ? (q[1:0] & {2{busy}}) : q[1:0];
    return q[SEL_POLARITY] ? on : ~on;
  endfunction
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  AST_SEL_MANUAL: assert property (master_mode_i && $stable(master_mode_i) && !sel_q[SEL_AUTO]
    |=> select_lines_o == want($past(sel_q), $past(xfer_busy_i))) else $error("manual select level wrong");
  AST_SEL_AUTO: assert property (master_mode_i && $stable(master_mode_i) && sel_q[SEL_AUTO]
    |=> select_lines_o == want($past(sel_q), $past(xfer_busy_i))) else $error("auto select level wrong");
  AST_SLAVE_PIN: assert property (!master_mode_i |=> select_oe_o == 2'b10)
    else $error("first select pin driven in slave mode");
  AST_THREE_WIRE: assert property (!master_mode_i && sel_q[SEL_THREE_WIRE] |=> slave_selected_o)
    else $error("three-wire slave not selected");
  AST_DMA_RESET: assert property (req_i.wr && req_i.addr == ADDR_DMA && req_i.wdata[DMA_RESET]
    |=> dma_logic_reset_o ##1 !dma_logic_reset_o) else $error("DMA reset pulse wrong");
  AST_RX_REQ: assert property (rx_dma_req_o |-> $past(rx_not_empty_i)) else $error("rx request without data");
  AST_RX_DONE: assert property (dma_i.rx_done && !req_i.wr |=> !rx_dma_req_o [*3])
    else $error("rx request after done");
  AST_TX_DONE: assert property (dma_i.tx_done && !req_i.wr |=> !tx_dma_req_o [*3])
    else $error("tx request after done");
  AST_TX_ROOM: assert property (tx_dma_req_o |-> $past(tx_has_room_i)) else $error("tx request without room");
  AST_TIMEOUT_IRQ: assert property (timeout_i && !master_mode_i && sel_q[SEL_TIMEOUT_IEN] && ien_q
    |=> irq_o) else $error("time-out interrupt missing");
  cover property (dma_i.rx_done);
  cover property (master_mode_i && sel_q[SEL_AUTO] && xfer_busy_i);
  cover property (dma_logic_reset_o);
endmodule

/* verification/dma_partner.sv */
/* DMA controller model: acks requests, with a gap when slow, and ends
   each block of WORDS words with a done pulse. Runs on the system clock. */
`timescale 1ns/1ps
module dma_partner
  import spi_sel_pkg::*;
#(parameter int WORDS = 3)
(
  input  wire logic            clk_i,
  input  wire logic            reset_i,
  input  wire logic [1:0]      req_i,  // Requests, receive in bit 1.
  input  wire logic            slow_i, // Stretch the gap between acks.
  output spi_sel_pkg::dma_in_s dma_o
);
  int         cnt [2]; // Words acked, transmit first.
  int         gap;     // Cycles left before another ack.
  logic [1:0] ack;     // Acks to send this cycle.
  logic [1:0] done;    // Done pulses to send this cycle.
  // No ack while the previous one stands: the request has not dropped yet.
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt = '{0, 0};
      gap = 0;
      dma_o <= '0;
    end else begin
      ack = 2'h0;
      done = 2'h0;
      gap = (gap > 0) ? gap - 1 : 0;
      for (int d = 0; d < 2; d++) begin
        if (cnt[d] == WORDS) begin
          cnt[d] = 0;
          done[d] = 1'b1;
        end else if (req_i[d] && !(d ? dma_o.rx_ack : dma_o.tx_ack) && gap == 0) begin
          cnt[d]++;
          ack[d] = 1'b1;
          gap = slow_i ? 4 : 0;
        end
      end
      dma_o <= '{rx_done: done[1], tx_done: done[0], rx_ack: ack[1], tx_ack: ack[0]};
    end
  end
endmodule

/* verification/tb.sv */
/* Testbench for the select and DMA request block with a DMA model.
   Assumes a 200 MHz clock and a 160 ns serial clock within frames. */
`timescale 1ns/1ps
module tb;
  import spi_sel_pkg::*;
  logic clk = 0, reset = 1, master = 1, busy = 0, tout = 0, rxne = 0, room = 0, sel0 = 1, sclk = 0, slow = 0;
  reg_req_s    req = '0;
  dma_in_s     dma;
  logic [31:0] rdata, r, seed = 32'h55;
  logic [1:0]  lines, oe;
  logic        slvsel, rise, rxreq, txreq, dmarst, irq;
  int          mismatches = 0, n_compared = 0, rises = 0, done_cnt [2] = '{0, 0}, rst_pulses = 0;
  always #2.5 clk = ~clk;
  always @(negedge clk) begin
    rises += int'(rise);
    rst_pulses += int'(dmarst);
    done_cnt[0] += int'(dma.rx_done);
    done_cnt[1] += int'(dma.tx_done);
  end
  spi_select_and_dma_request spi_select_and_dma_request_i (.clk_i(clk), .reset_i(reset), .req_i(req),
    .rdata_o(rdata), .master_mode_i(master), .xfer_busy_i(busy), .timeout_i(tout), .rx_not_empty_i(rxne),
    .tx_has_room_i(room), .dma_i(dma), .select0_pin_i(sel0), .serial_clock_pin_i(sclk), .select_lines_o(lines),
    .select_oe_o(oe), .slave_selected_o(slvsel), .link_clk_rise_o(rise), .rx_dma_req_o(rxreq),
    .tx_dma_req_o(txreq), .dma_logic_reset_o(dmarst), .irq_o(irq));
  dma_partner dma_partner_i (.clk_i(clk), .reset_i(reset), .req_i({rxreq, txreq}), .slow_i(slow), .dma_o(dma));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected pins: auto mode keeps a line active only while busy.
  function automatic logic [1:0] sel_exp(input int v, input logic b);
    logic [1:0] act;
    act = v[1:0] & ((v[3] && !b) ? 2'b00 : 2'b11);
    return v[2] ? act : ~act;
  endfunction
  task automatic tally(input bit ok, input string what);
    n_compared++;
    if (!ok) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tally(got === exp, "register value");
  endtask
  task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
    tally(got === exp, "pin levels");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk_reg(rdata, exp);
  endtask
  task automatic pulse_timeout();
    @(posedge clk);
    tout <= 1'b1;
    @(posedge clk);
    tout <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #50000;
    mismatches++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(ADDR_SELECT, 32'h0);
    rd(ADDR_DMA, 32'h0);
    rd(ADDR_IRQ_CLEAR, 32'h0);
    rd(8'h40, 32'h0);
    $display("test reset values done");
    for (int v = 0; v < 16; v++) begin
      r = xs();
      @(posedge clk);
      busy <= r[0];
      wr(ADDR_SELECT, 32'(v));
      repeat (2) @(posedge clk);
      #1 chk_pin({oe, lines}, {2'b11, sel_exp(v, busy)});
    end
    $display("test master select done");
    @(posedge clk);
    master <= 1'b0;
    wr(ADDR_SELECT, 32'h20);
    wr(ADDR_IRQ_ENABLE, 32'h1);
    repeat (6) @(posedge clk);
    #1 chk_pin({oe, 1'b0, slvsel}, 4'h8);
    rises = 0;
    sel0 <= 1'b0;
    #1.7;
    repeat (8) begin
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
    pulse_timeout();
    #1 chk_pin({2'b0, slvsel, irq}, 4'h3);
    chk_reg(32'(rises), 32'h8);
    rd(ADDR_IRQ_STATUS, 32'h9);
    wr(ADDR_IRQ_CLEAR, 32'hF);
    sel0 <= 1'b1;
    wr(ADDR_SELECT, 32'h10);
    pulse_timeout();
    #1 chk_pin({2'b0, slvsel, irq}, 4'h2);
    $display("test slave and link done");
    master <= 1'b1;
    wr(ADDR_IRQ_CLEAR, 32'hF);
    for (int k = 0; k < 2; k++) begin
      slow <= k[0];
      wr(ADDR_DMA, k ? 32'h1 : 32'h2);
      for (int n = 0; n < 600 && done_cnt[k] == 0; n++) begin
        r = xs();
        @(posedge clk);
        rxne <= r[0];
        room <= r[1];
      end
      rd(ADDR_DMA, 32'h0);
    end
    rd(ADDR_IRQ_STATUS, 32'h6);
    rxne <= 1'b1;
    room <= 1'b1;
    wr(ADDR_DMA, 32'h3);
    wr(ADDR_DMA, 32'h4);
    repeat (4) @(posedge clk);
    #1 chk_pin({2'b0, rxreq, txreq}, 4'h0);
    rd(ADDR_DMA, 32'h0);
    chk_reg(32'(rst_pulses), 32'h1);
    $display("test DMA done");
    close_out();
  end
endmodule
bind spi_select_and_dma_request spi_sel_props spi_sel_props_i (.clk_i, .reset_i, .req_i, .master_mode_i,
  .xfer_busy_i, .timeout_i, .rx_not_empty_i, .tx_has_room_i, .dma_i, .select_lines_o, .select_oe_o,
  .slave_selected_o, .rx_dma_req_o, .tx_dma_req_o, .dma_logic_reset_o, .irq_o);
